/* File: pme_pkg.sv */
`default_nettype none
package pme_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int AW = 8;
  localparam int DW = 32;

  localparam logic [AW-1:0] OFS_CONTROL     = 8'h00;
  localparam logic [AW-1:0] OFS_ALIVE_MAP   = 8'h04;
  localparam logic [AW-1:0] OFS_LINK_MAP    = 8'h08;
  localparam logic [AW-1:0] OFS_LINK_RAW    = 8'h0c;
  localparam logic [AW-1:0] OFS_LINK_MASKED = 8'h10;
  localparam logic [AW-1:0] OFS_DONE_RAW    = 8'h14;
  localparam logic [AW-1:0] OFS_DONE_MASKED = 8'h18;
  localparam logic [AW-1:0] OFS_MASK_SET    = 8'h1c;
  localparam logic [AW-1:0] OFS_MASK_CLEAR  = 8'h20;
  localparam logic [AW-1:0] OFS_USER0       = 8'h24;
  localparam logic [AW-1:0] OFS_USER1       = 8'h28;
  localparam logic [AW-1:0] OFS_PHY_SELECT  = 8'h2c;
  localparam logic [AW-1:0] OFS_IRQ_CTRL    = 8'h30;
  localparam logic [AW-1:0] OFS_PACING      = 8'h34;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_BUSY_BIT   = 31;
  localparam int CTRL_ENABLE_BIT = 17;
  localparam int CTRL_PRE_OFF_BIT = 16;
  localparam int UA_GO_BIT       = 31;
  localparam int UA_WRITE_BIT    = 30;
  localparam int UA_ACK_BIT      = 29;
  localparam int UA_REG_LSB      = 21;
  localparam int UA_PHY_LSB      = 16;
  localparam int SEL_LINKEN_BIT  = 6;
  localparam int PACE_W          = 17;
  localparam logic [PACE_W-1:0] PACE_RST = 17'h00000;

  // ----------------------------------------------------------------
  // Management frame layout (bit index within a 64-bit frame)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_START = 6'd32;
  localparam logic [5:0] IDX_OP    = 6'd34;
  localparam logic [5:0] IDX_PHY   = 6'd36;
  localparam logic [5:0] IDX_REG   = 6'd41;
  localparam logic [5:0] IDX_TA    = 6'd46;
  localparam logic [5:0] IDX_DATA  = 6'd48;
  localparam logic [5:0] IDX_LAST  = 6'd63;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [4:0] STATUS_REG = 5'h01;
  localparam int LINK_UP_BIT = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CORE_HZ     = 125_000_000;
  localparam int MGMT_MAX_HZ = 2_500_000;
  localparam int MGMT_TYP_HZ = 1_000_000;
  localparam int MIN_HALF_CYC = (CORE_HZ + 2 * MGMT_MAX_HZ - 1) / (2 * MGMT_MAX_HZ);
  localparam int TYP_HALF_CYC = (CORE_HZ + 2 * MGMT_TYP_HZ - 1) / (2 * MGMT_TYP_HZ);
  localparam logic [15:0] DIV_MIN = 16'(MIN_HALF_CYC - 1);
  localparam logic [15:0] DIV_RST = 16'(TYP_HALF_CYC - 1);

  typedef enum logic {PME_IDLE, PME_FRAME} pme_state_t;

endpackage : pme_pkg
`default_nettype wire

/* File: pme_top.sv */
`timescale 1ns/10ps
`default_nettype none

module pme_top
  import pme_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Register port
  input  wire logic [pme_pkg::AW-1:0] bus_addr,
  input  wire logic [pme_pkg::DW-1:0] bus_wr_data,
  input  wire logic                  bus_wr_en,
  input  wire logic                  bus_rd_en,
  output var  logic [pme_pkg::DW-1:0] bus_rd_data,
  // Management pins
  output var  logic                  mgmt_clock_pin,
  input  wire logic                  mgmt_data_in,
  output var  logic                  mgmt_data_out,
  output var  logic                  mgmt_data_oe,
  // Interrupt
  input  wire logic                  mac_event_in,
  output var  logic                  irq_out
);
  import pme_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic frame_bit(input logic [5:0] idx, input logic wr,
                                     input logic [4:0] pa, input logic [4:0] ra,
                                     input logic [15:0] d);
    int i;
    logic [1:0] op;
    i  = int'(idx);
    op = wr ? OP_WRITE : OP_READ;
    if (idx < IDX_START)      frame_bit = 1'b1;
    else if (idx < IDX_OP)    frame_bit = (idx == IDX_START) ? 1'b0 : 1'b1;
    else if (idx < IDX_PHY)   frame_bit = op[35 - i];
    else if (idx < IDX_REG)   frame_bit = pa[40 - i];
    else if (idx < IDX_TA)    frame_bit = ra[45 - i];
    else if (idx < IDX_DATA)  frame_bit = (idx == IDX_TA);
    else                      frame_bit = d[63 - i];
  endfunction : frame_bit

  function automatic logic frame_oe(input logic [5:0] idx, input logic wr);
    frame_oe = wr | (idx < IDX_TA);
  endfunction : frame_oe

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                enable_reg, pre_off_reg;
  logic [15:0]         div_reg;
  logic [31:0]         alive_reg, link_reg;
  logic                link_raw_reg, link_en_reg;
  logic [4:0]          mon_addr_reg;
  logic [1:0]          done_raw_reg, done_mask_reg;
  logic [1:0]          go_reg, wr_reg, ack_reg;
  logic [4:0]          ra_reg [2];
  logic [4:0]          pa_reg [2];
  logic [15:0]         dat_reg [2];
  logic                gie_reg, irq_reg;
  logic [PACE_W-1:0]   pace_reload_reg, pace_cnt_reg;
  logic [DW-1:0]       rd_data_reg;
  pme_state_t          state_reg;
  logic [5:0]          idx_reg;
  logic [15:0]         div_cnt_reg;
  logic                mdc_reg, mdo_reg, moe_reg;
  logic                cur_user_reg, cur_ch_reg, cur_wr_reg;
  logic [4:0]          cur_pa_reg, cur_ra_reg, poll_addr_reg;
  logic [15:0]         cur_dat_reg, shift_reg;
  logic                ack_smp_reg, rr_last_reg;
  logic                mdi_meta_reg, mdi_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_ctrl   = bus_wr_en && bus_addr == OFS_CONTROL;
  wire wr_lraw   = bus_wr_en && bus_addr == OFS_LINK_RAW;
  wire wr_draw   = bus_wr_en && bus_addr == OFS_DONE_RAW;
  wire wr_mset   = bus_wr_en && bus_addr == OFS_MASK_SET;
  wire wr_mclr   = bus_wr_en && bus_addr == OFS_MASK_CLEAR;
  wire wr_ua0    = bus_wr_en && bus_addr == OFS_USER0;
  wire wr_ua1    = bus_wr_en && bus_addr == OFS_USER1;
  wire wr_sel    = bus_wr_en && bus_addr == OFS_PHY_SELECT;
  wire wr_ictl   = bus_wr_en && bus_addr == OFS_IRQ_CTRL;
  wire wr_pace   = bus_wr_en && bus_addr == OFS_PACING;
  wire [1:0] wr_ua = {wr_ua1, wr_ua0};

  // Management clock: the divider is clamped so the pin never beats the bus limit
  wire [15:0] half_m1   = (div_reg < DIV_MIN) ? DIV_MIN : div_reg;
  wire        tick      = enable_reg && div_cnt_reg == 16'h0000;
  wire        rise_tick = tick && !mdc_reg;
  wire        fall_tick = tick && mdc_reg;
  wire        in_frame  = state_reg == PME_FRAME;
  wire        frame_end = in_frame && fall_tick && idx_reg == IDX_LAST;
  wire        start     = state_reg == PME_IDLE && fall_tick;

  // User accesses win over polling; between themselves they alternate
  wire        any_go   = |go_reg;
  wire        pick_ch  = (&go_reg) ? !rr_last_reg : go_reg[1];
  wire        s_wr     = any_go & wr_reg[pick_ch];
  wire [4:0]  s_pa     = any_go ? pa_reg[pick_ch] : poll_addr_reg;
  wire [4:0]  s_ra     = any_go ? ra_reg[pick_ch] : STATUS_REG;
  wire [15:0] s_dat    = dat_reg[pick_ch];
  wire [5:0]  s_idx    = pre_off_reg ? IDX_START : 6'h00;
  wire [5:0]  n_idx    = idx_reg + 6'h01;

  wire        rd_done   = frame_end && !cur_wr_reg;
  wire        new_link  = ack_smp_reg && shift_reg[LINK_UP_BIT];
  wire        poll_done = frame_end && !cur_user_reg;
  wire        link_chg  = poll_done && cur_pa_reg == mon_addr_reg &&
                          new_link != link_reg[cur_pa_reg] && link_en_reg;
  wire        user_done = frame_end && cur_user_reg;
  wire [1:0]  done_set  = user_done ? (cur_ch_reg ? 2'h2 : 2'h1) : 2'h0;

  wire        link_masked = link_raw_reg & link_en_reg;
  wire [1:0]  done_masked = done_raw_reg & done_mask_reg;
  wire        pending     = link_masked | (|done_masked) | mac_event_in;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      enable_reg  <= 1'b0;
      pre_off_reg <= 1'b0;
      div_reg     <= DIV_RST;
      mon_addr_reg <= 5'h00;
      link_en_reg <= 1'b0;
      gie_reg     <= 1'b0;
      pace_reload_reg <= PACE_RST;
    end else begin
      if (wr_ctrl) begin
        enable_reg  <= bus_wr_data[CTRL_ENABLE_BIT];
        pre_off_reg <= bus_wr_data[CTRL_PRE_OFF_BIT];
        div_reg     <= bus_wr_data[15:0];
      end
      if (wr_sel) begin
        mon_addr_reg <= bus_wr_data[4:0];
        link_en_reg  <= bus_wr_data[SEL_LINKEN_BIT];
      end
      if (wr_ictl) gie_reg <= bus_wr_data[0];
      if (wr_pace) pace_reload_reg <= bus_wr_data[PACE_W-1:0];
    end
  end

  // Event flags: a hardware set in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link_raw_reg  <= 1'b0;
      done_raw_reg  <= 2'h0;
      done_mask_reg <= 2'h0;
    end else begin
      link_raw_reg  <= (link_raw_reg & !(wr_lraw & bus_wr_data[0])) | link_chg;
      done_raw_reg  <= (done_raw_reg & ~({2{wr_draw}} & bus_wr_data[1:0])) | done_set;
      done_mask_reg <= (done_mask_reg | ({2{wr_mset}} & bus_wr_data[1:0])) &
                       ~({2{wr_mclr}} & bus_wr_data[1:0]);
    end
  end

  // ----------------------------------------------------------------
  // User access registers
  // ----------------------------------------------------------------
  // A write while go is set is dropped so a running access keeps its fields
  always_ff @(posedge core_clk) begin
    if (rst) begin
      go_reg  <= 2'h0;
      wr_reg  <= 2'h0;
      ack_reg <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        ra_reg[c]  <= 5'h00;
        pa_reg[c]  <= 5'h00;
        dat_reg[c] <= 16'h0000;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wr_ua[c] && !go_reg[c]) begin
          go_reg[c]  <= bus_wr_data[UA_GO_BIT];
          wr_reg[c]  <= bus_wr_data[UA_WRITE_BIT];
          ack_reg[c] <= 1'b0;
          ra_reg[c]  <= bus_wr_data[UA_REG_LSB +: 5];
          pa_reg[c]  <= bus_wr_data[UA_PHY_LSB +: 5];
          dat_reg[c] <= bus_wr_data[15:0];
        end else if (done_set[c]) begin
          go_reg[c]  <= 1'b0;
          ack_reg[c] <= !cur_wr_reg && ack_smp_reg;
          if (!cur_wr_reg) dat_reg[c] <= shift_reg;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // PHY maps
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alive_reg <= 32'h00000000;
      link_reg  <= 32'h00000000;
    end else begin
      if (rd_done) alive_reg[cur_pa_reg] <= ack_smp_reg;
      if (poll_done) link_reg[cur_pa_reg] <= new_link;
    end
  end

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  // Pin input crosses into the core clock through two flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mdi_meta_reg <= 1'b1;
      mdi_reg      <= 1'b1;
    end else begin
      mdi_meta_reg <= mgmt_data_in;
      mdi_reg      <= mdi_meta_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !enable_reg) begin
      div_cnt_reg <= 16'h0000;
      mdc_reg     <= 1'b0;
    end else begin
      div_cnt_reg <= tick ? half_m1 : div_cnt_reg - 16'h0001;
      if (tick) mdc_reg <= !mdc_reg;
    end
  end

  // Bits change on the falling edge, PHY data is taken at the rising edge
  always_ff @(posedge core_clk) begin
    if (rst || !enable_reg) begin
      state_reg    <= PME_IDLE;
      idx_reg      <= 6'h00;
      mdo_reg      <= 1'b1;
      moe_reg      <= 1'b0;
      cur_user_reg <= 1'b0;
      cur_ch_reg   <= 1'b0;
      cur_wr_reg   <= 1'b0;
      cur_pa_reg   <= 5'h00;
      cur_ra_reg   <= STATUS_REG;
      cur_dat_reg  <= 16'h0000;
      ack_smp_reg  <= 1'b0;
      shift_reg    <= 16'h0000;
    end else if (start) begin
      state_reg    <= PME_FRAME;
      idx_reg      <= s_idx;
      mdo_reg      <= frame_bit(s_idx, s_wr, s_pa, s_ra, s_dat);
      moe_reg      <= 1'b1;
      cur_user_reg <= any_go;
      cur_ch_reg   <= pick_ch;
      cur_wr_reg   <= s_wr;
      cur_pa_reg   <= s_pa;
      cur_ra_reg   <= s_ra;
      cur_dat_reg  <= s_dat;
      ack_smp_reg  <= 1'b0;
    end else if (frame_end) begin
      state_reg <= PME_IDLE;
      mdo_reg   <= 1'b1;
      moe_reg   <= 1'b0;
    end else if (in_frame && fall_tick) begin
      idx_reg <= n_idx;
      mdo_reg <= frame_bit(n_idx, cur_wr_reg, cur_pa_reg, cur_ra_reg, cur_dat_reg);
      moe_reg <= frame_oe(n_idx, cur_wr_reg);
    end else if (in_frame && rise_tick) begin
      // Second turnaround bit pulled low means the PHY answered
      if (idx_reg == IDX_TA + 6'h01) ack_smp_reg <= !mdi_reg;
      if (idx_reg >= IDX_DATA) shift_reg <= {shift_reg[14:0], mdi_reg};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      poll_addr_reg <= 5'h00;
      rr_last_reg   <= 1'b1;
    end else begin
      if (poll_done) poll_addr_reg <= poll_addr_reg + 5'h01;
      if (start && any_go) rr_last_reg <= pick_ch;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt combiner and pacing
  // ----------------------------------------------------------------
  wire gie_rise = wr_ictl && bus_wr_data[0] && !gie_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pace_cnt_reg <= PACE_RST;
      irq_reg      <= 1'b0;
    end else begin
      if (gie_rise) pace_cnt_reg <= pace_reload_reg;
      else if (pace_cnt_reg != PACE_RST) pace_cnt_reg <= pace_cnt_reg - 17'h00001;
      // High while already high; may only rise once pacing expired
      irq_reg <= gie_reg && pending &&
                 (irq_reg || pace_cnt_reg == PACE_RST);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [DW-1:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (bus_addr)
      OFS_CONTROL:     rd_mux = {in_frame, 13'h0000, enable_reg, pre_off_reg, div_reg};
      OFS_ALIVE_MAP:   rd_mux = alive_reg;
      OFS_LINK_MAP:    rd_mux = link_reg;
      OFS_LINK_RAW:    rd_mux = {31'h00000000, link_raw_reg};
      OFS_LINK_MASKED: rd_mux = {31'h00000000, link_masked};
      OFS_DONE_RAW:    rd_mux = {30'h00000000, done_raw_reg};
      OFS_DONE_MASKED: rd_mux = {30'h00000000, done_masked};
      OFS_MASK_SET,
      OFS_MASK_CLEAR:  rd_mux = {30'h00000000, done_mask_reg};
      OFS_USER0:       rd_mux = {go_reg[0], wr_reg[0], ack_reg[0], 3'h0, ra_reg[0],
                                 pa_reg[0], dat_reg[0]};
      OFS_USER1:       rd_mux = {go_reg[1], wr_reg[1], ack_reg[1], 3'h0, ra_reg[1],
                                 pa_reg[1], dat_reg[1]};
      OFS_PHY_SELECT:  rd_mux = {25'h0000000, link_en_reg, 1'b0, mon_addr_reg};
      OFS_IRQ_CTRL:    rd_mux = {31'h00000000, gie_reg};
      OFS_PACING:      rd_mux = {15'h0000, pace_reload_reg};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) rd_data_reg <= 32'h00000000;
    else     rd_data_reg <= bus_rd_en ? rd_mux : 32'h00000000;
  end

  assign bus_rd_data    = rd_data_reg;
  assign mgmt_clock_pin = mdc_reg;
  assign mgmt_data_out  = mdo_reg;
  assign mgmt_data_oe   = moe_reg;
  assign irq_out        = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_silent_when_off;
    !enable_reg |=> !mgmt_data_oe && !mgmt_clock_pin && state_reg == PME_IDLE;
  endproperty
  a_silent_when_off: assert property (p_silent_when_off)
    else $error("bus active while disabled");

  property p_preamble_first;
    start && !pre_off_reg |=> idx_reg == 6'h00 && mgmt_data_out && mgmt_data_oe;
  endproperty
  a_preamble_first: assert property (p_preamble_first)
    else $error("frame did not open with preamble");

  property p_done_clears_go;
    user_done && !cur_ch_reg |=> !go_reg[0] && done_raw_reg[0];
  endproperty
  a_done_clears_go: assert property (p_done_clears_go)
    else $error("completion did not clear go or set done");

  property p_alive_set;
    rd_done && ack_smp_reg |=> alive_reg[cur_pa_reg];
  endproperty
  a_alive_set: assert property (p_alive_set)
    else $error("responding phy not marked alive");

  property p_link_needs_ack;
    poll_done && !ack_smp_reg |=> !link_reg[cur_pa_reg];
  endproperty
  a_link_needs_ack: assert property (p_link_needs_ack)
    else $error("link set without answer");

  property p_read_data;
    user_done && !cur_wr_reg && cur_ch_reg |=> dat_reg[1] == $past(shift_reg);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data not stored");

  property p_round_robin;
    start && (&go_reg) && !rr_last_reg |=> cur_user_reg && cur_ch_reg;
  endproperty
  a_round_robin: assert property (p_round_robin)
    else $error("round robin order broken");

  property p_gate_low;
    !gie_reg |=> !irq_out;
  endproperty
  a_gate_low: assert property (p_gate_low)
    else $error("interrupt high while disabled");

  property p_pacing_holds;
    pace_cnt_reg != PACE_RST && !irq_out |=> !irq_out;
  endproperty
  a_pacing_holds: assert property (p_pacing_holds)
    else $error("interrupt rose during pacing");

  property p_no_delay;
    gie_reg && pending && pace_cnt_reg == PACE_RST |=> irq_out;
  endproperty
  a_no_delay: assert property (p_no_delay)
    else $error("interrupt delayed after pacing expired");

  c_user_read:   cover property (user_done && !cur_wr_reg && ack_smp_reg);
  c_link_change: cover property (link_chg);
  c_irq_rise:    cover property ($rose(irq_out));
  c_both_queued: cover property (start && (&go_reg));

endmodule : pme_top
`default_nettype wire

/* File: pme_phy_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// Management-bus PHY at one address
// ------------------------------------------
module pme_phy_model
  import pme_pkg::*;
#(
  parameter logic [4:0] PHY = 5'h02
) (
  // Pins
  input  wire logic        mgmt_clock_pin,
  input  wire logic        mgmt_data_out,
  input  wire logic        mgmt_data_oe,
  output var  logic        mgmt_data_in,
  // Status and capture
  input  wire logic        link_up,
  output var  logic [15:0] wr_data
);
  logic [13:0]      sh = '0;
  logic [15:0]      rdat = '0;
  logic             rd = 1'b0;
  logic             drv = 1'b0;
  logic             dv = 1'b1;
  int               cnt = 0;
  wire logic [13:0] nx = {sh[12:0], mgmt_data_out};
  // Pull-up: a released or unanswered line reads high
  assign mgmt_data_in = mgmt_data_oe ? mgmt_data_out : (drv ? dv : 1'b1);
  always @(posedge mgmt_clock_pin) begin
    if (cnt > 0) begin
      cnt <= cnt - 1;
      if (!rd)
        wr_data <= {wr_data[14:0], mgmt_data_out};
    end else if (mgmt_data_oe) begin
      sh <= nx;
      if (nx[13:5] == {4'b0110, PHY} || nx[13:5] == {4'b0101, PHY}) begin
        cnt <= 18;
        sh <= '0;
        rd <= nx[11];
        rdat <= (nx[4:0] == STATUS_REG) ? 16'(link_up) << LINK_UP_BIT : {11'h5a3, nx[4:0]};
      end
    end else
      sh <= '0;
  end
  // Answer changes on falling edges so the engine samples it settled
  always @(negedge mgmt_clock_pin) begin
    drv <= rd && cnt > 0 && cnt < 18;
    dv <= (cnt == 17) ? 1'b0 : rdat[(cnt + 15) % 16];
  end
endmodule : pme_phy_model
`default_nettype wire

/* File: tb_phy_management_engine.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_phy_management_engine;
  import pme_pkg::*;
  localparam logic [4:0] PA = 5'h02;
  logic          core_clk = 0;
  logic          rst = 1;
  logic          wr = 0;
  logic          rd = 0;
  logic          mac = 0;
  logic          link = 1;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wd = '0;
  logic [DW-1:0] rdd;
  logic [DW-1:0] v;
  logic          mdc, mdo, oe, mdi, irq;
  logic [15:0]   wdat;
  int            bad_count = 0;
  int            num_checks = 0;
  realtime       t;
  pme_top dut_u (.core_clk(core_clk), .rst(rst), .bus_addr(addr), .bus_wr_data(wd),
    .bus_wr_en(wr), .bus_rd_en(rd), .bus_rd_data(rdd), .mgmt_clock_pin(mdc),
    .mgmt_data_in(mdi), .mgmt_data_out(mdo), .mgmt_data_oe(oe), .mac_event_in(mac),
    .irq_out(irq));
  pme_phy_model #(.PHY(PA)) phy_u (.mgmt_clock_pin(mdc), .mgmt_data_out(mdo),
    .mgmt_data_oe(oe), .mgmt_data_in(mdi), .link_up(link), .wr_data(wdat));
  initial forever #4 core_clk = ~core_clk;
  // ------------------------------------------
  // Bus tasks
  // ------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bw(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge core_clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : bw
  task automatic rc(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 v = rdd;
    chk(v, e);
  endtask : rc
  // Polls go with a bound; a hung engine leaves go set and fails the checks
  task automatic wgo(input logic [AW-1:0] a);
    for (int i = 0; i < 4000; i++) begin
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 v = rdd;
      if (v[31] === 1'b0)
        break;
    end
  endtask : wgo
  function automatic logic [31:0] ua(input logic w, input logic [4:0] ra,
                                     input logic [4:0] pa, input logic [15:0] d);
    return {1'b1, w, 1'b0, 3'b000, ra, pa, d};
  endfunction : ua
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (95000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end
  // ------------------------------------------
  // Tests
  // ------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rc(OFS_CONTROL, 32'(DIV_RST));
    repeat (200) @(posedge core_clk);
    chk(32'(mdc | oe), 32'h0);
    rc(8'h3c, 32'h0);
    bw(OFS_PHY_SELECT, 32'h42);
    bw(OFS_CONTROL, 32'h0003_0000);
    @(posedge mdc);
    t = $realtime;
    @(negedge mdc);
    chk(32'(int'(($realtime - t) / 8)), 32'(DIV_MIN + 1));
    repeat (6000) @(posedge core_clk);
    rc(OFS_ALIVE_MAP, 32'h4);
    rc(OFS_LINK_MAP, 32'h4);
    rc(OFS_LINK_RAW, 32'h1);
    bw(OFS_LINK_RAW, 32'h1);
    link <= 1'b0;
    repeat (54000) @(posedge core_clk);
    rc(OFS_LINK_RAW, 32'h1);
    rc(OFS_LINK_MAP, 32'h0);
    rc(OFS_ALIVE_MAP, 32'h4);
    bw(OFS_MASK_SET, 32'h1);
    bw(OFS_USER0, ua(1'b1, 5'h04, PA, 16'hbeef));
    bw(OFS_USER1, ua(1'b0, 5'h03, 5'h07, 16'h0));
    wgo(OFS_USER0);
    wgo(OFS_USER1);
    chk(32'(v[31:29]), 32'h0);
    chk(32'(wdat), 32'hbeef);
    rc(OFS_DONE_RAW, 32'h3);
    rc(OFS_DONE_MASKED, 32'h1);
    bw(OFS_DONE_RAW, 32'h3);
    bw(OFS_CONTROL, 32'h0002_0000);
    bw(OFS_USER0, ua(1'b0, 5'h03, PA, 16'h0));
    wgo(OFS_USER0);
    chk(v, {6'b001000, 5'h03, PA, 11'h5a3, 5'h03});
    bw(OFS_MASK_CLEAR, 32'h1);
    rc(OFS_DONE_MASKED, 32'h0);
    bw(OFS_MASK_SET, 32'h1);
    bw(OFS_PACING, 32'h28);
    bw(OFS_IRQ_CTRL, 32'h1);
    repeat (20) @(posedge core_clk);
    #1 chk(32'(irq), 32'h0);
    repeat (30) @(posedge core_clk);
    #1 chk(32'(irq), 32'h1);
    bw(OFS_IRQ_CTRL, 32'h0);
    @(posedge core_clk);
    #1 chk(32'(irq), 32'h0);
    bw(OFS_LINK_RAW, 32'h1);
    bw(OFS_DONE_RAW, 32'h3);
    bw(OFS_PACING, 32'h0);
    bw(OFS_IRQ_CTRL, 32'h1);
    repeat (5) @(posedge core_clk);
    #1 chk(32'(irq), 32'h0);
    @(posedge core_clk);
    mac <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk(32'(irq), 32'h1);
    give_verdict();
  end
endmodule : tb_phy_management_engine
`default_nettype wire
